// ===== hdl/rsm_pkg.sv
// Purpose: shared constants and types for the seconds/minutes counter
// Assumes: 250 MHz system clock, APB register access
// Notes: offsets are byte addresses of aligned 32-bit words
package rsm_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] SEC_OFF = 8'h00;
	localparam logic [7:0] MIN_OFF = 8'h04;
	localparam logic [7:0] CTRL_OFF = 8'h08;
	localparam logic [7:0] DIV_OFF = 8'h0c;

	// ==========================================================
	// field positions
	localparam int BUSY_BIT = 7;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_FREE_BIT = 1;

	// ==========================================================
	// reset values
	localparam logic [6:0] TIME_RST = 7'h00;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] DIV_RST = 8'h00;

	// ==========================================================
	// timing
	localparam int CLK_HZ = 250000000;
	localparam int TICK_HZ = 1;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int BUSY_CYCLES = 2;

	// ==========================================================
	// types
	typedef struct packed {
		logic [2:0] tens;
		logic [3:0] units;
	} rsm_bcd_t;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [31:0] wdata;
	} rsm_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEC = 2'b01,
		ST_MIN = 2'b11
	} rsm_state_t;

endpackage

// ===== hdl/rsm_bcd_digit.sv
// Purpose: one BCD pair (tens, units) with load and carry
// Assumes: step is a one-cycle pulse
// Notes: wraps at the configured maximum
`timescale 1ns/1ns
module rsm_bcd_digit #(
	parameter logic [3:0] UNITS_MAX = 4'h9,
	parameter logic [2:0] TENS_MAX = 3'h5
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// control
	input wire logic step_i,
	input wire logic load_i,
	input wire rsm_pkg::rsm_bcd_t load_val_i,
	// result
	output rsm_pkg::rsm_bcd_t value_o,
	output logic wrap_o
);

	// ==========================================================
	// carry, combinational so the next stage steps in the same cycle
	assign wrap_o = step_i && !load_i && value_o.units == UNITS_MAX &&
		value_o.tens == TENS_MAX;

	// ==========================================================
	// counting
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			value_o <= rsm_pkg::TIME_RST;
		end
		else if (load_i)
		begin
			value_o <= load_val_i;
		end
		else if (step_i)
		begin
			if (value_o.units >= UNITS_MAX)
			begin
				value_o.units <= 4'h0;
				if (value_o.tens >= TENS_MAX)
				begin
					value_o.tens <= 3'h0;
				end
				else
				begin
					value_o.tens <= value_o.tens + 3'h1;
				end
			end
			else
			begin
				value_o.units <= value_o.units + 4'h1;
			end
		end
	end

endmodule

// ===== hdl/rsm_top.sv
// Purpose: seconds and minutes stage of a real-time clock
// Assumes: APB slave, one clock domain
// Notes: hour carry and divided clock leave on pins
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module rsm_top #(
	parameter int TICK_DIV = rsm_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// pins
	output logic divided_clock_out_pin_o,
	output logic hour_carry_o
);

	// ==========================================================
	// elaboration checks
	initial
	begin
		if (TICK_DIV < 4)
		begin
			$error("TICK_DIV too small");
		end
	end

	// ==========================================================
	// declarations
	rsm_pkg::rsm_req_t req;
	rsm_pkg::rsm_bcd_t sec_val;
	rsm_pkg::rsm_bcd_t min_val;
	rsm_pkg::rsm_state_t state;
	logic [31:0] tick_cnt;
	logic tick;
	logic [1:0] ctrl;
	logic [7:0] div_sel;
	logic [7:0] free_cnt;
	logic [7:0] div_cnt;
	logic sec_wrap;
	logic min_wrap;
	logic sec_step;
	logic sec_load;
	logic min_load;
	logic wr_acc;
	logic rd_acc;
	logic busy;
	logic [31:0] next_rdata;

	assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};
	assign wr_acc = psel_i && penable_i && req.write;
	assign rd_acc = psel_i && penable_i && !req.write;

	// ==========================================================
	// one hertz timebase
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end
		else if (!ctrl[rsm_pkg::CTRL_RUN_BIT])
		begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end
		else if (tick_cnt == 32'(TICK_DIV - 1))
		begin
			tick_cnt <= 32'h0;
			tick <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 32'h1;
			tick <= 1'b0;
		end
	end

	// ==========================================================
	// update sequencer, drives busy flag
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= rsm_pkg::ST_IDLE;
		end
		else
		begin
			case (state)
				rsm_pkg::ST_IDLE:
				begin
					if (tick)
					begin
						state <= rsm_pkg::ST_SEC;
					end
				end
				rsm_pkg::ST_SEC:
				begin
					state <= rsm_pkg::ST_MIN;
				end
				rsm_pkg::ST_MIN:
				begin
					state <= rsm_pkg::ST_IDLE;
				end
				default:
				begin
					state <= rsm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign busy = state != rsm_pkg::ST_IDLE;
	assign sec_step = state == rsm_pkg::ST_SEC &&
		!ctrl[rsm_pkg::CTRL_FREE_BIT];

	// ==========================================================
	// digit writes; free mode blocks seconds writes
	assign sec_load = wr_acc && req.addr == rsm_pkg::SEC_OFF &&
		!ctrl[rsm_pkg::CTRL_FREE_BIT];
	assign min_load = wr_acc && req.addr == rsm_pkg::MIN_OFF;

	rsm_bcd_digit #(
		.UNITS_MAX(4'h9),
		.TENS_MAX(3'h5)
	) u_sec (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.step_i(sec_step),
		.load_i(sec_load),
		.load_val_i(rsm_pkg::rsm_bcd_t'(req.wdata[6:0])),
		.value_o(sec_val),
		.wrap_o(sec_wrap)
	);

	rsm_bcd_digit #(
		.UNITS_MAX(4'h9),
		.TENS_MAX(3'h5)
	) u_min (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.step_i(sec_wrap),
		.load_i(min_load),
		.load_val_i(rsm_pkg::rsm_bcd_t'(req.wdata[6:0])),
		.value_o(min_val),
		.wrap_o(min_wrap)
	);

	// ==========================================================
	// hour carry pulse
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			hour_carry_o <= 1'b0;
		end
		else
		begin
			hour_carry_o <= min_wrap;
		end
	end

	// ==========================================================
	// free-running counter
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			free_cnt <= 8'h00;
		end
		else if (!ctrl[rsm_pkg::CTRL_FREE_BIT])
		begin
			free_cnt <= 8'h00;
		end
		else if (tick)
		begin
			free_cnt <= free_cnt + 8'h01;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctrl <= rsm_pkg::CTRL_RST;
			div_sel <= rsm_pkg::DIV_RST;
		end
		else if (wr_acc && req.addr == rsm_pkg::CTRL_OFF)
		begin
			ctrl <= req.wdata[1:0];
		end
		else if (wr_acc && req.addr == rsm_pkg::DIV_OFF)
		begin
			div_sel <= req.wdata[7:0];
		end
	end

	// ==========================================================
	// divided clock output, toggles every div_sel+1 ticks
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_cnt <= 8'h00;
			divided_clock_out_pin_o <= 1'b0;
		end
		else if (tick)
		begin
			if (div_cnt >= div_sel)
			begin
				div_cnt <= 8'h00;
				divided_clock_out_pin_o <= !divided_clock_out_pin_o;
			end
			else
			begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

	// ==========================================================
	// apb read path, zero wait states
	always_comb
	begin
		next_rdata = 32'h0;
		case (req.addr)
			rsm_pkg::SEC_OFF:
			begin
				if (ctrl[rsm_pkg::CTRL_FREE_BIT])
				begin
					next_rdata = {24'h0, free_cnt};
				end
				else
				begin
					next_rdata = {24'h0, busy, sec_val};
				end
			end
			rsm_pkg::MIN_OFF:
			begin
				next_rdata = {24'h0, busy, min_val};
			end
			rsm_pkg::CTRL_OFF:
			begin
				next_rdata = {30'h0, ctrl};
			end
			rsm_pkg::DIV_OFF:
			begin
				next_rdata = {24'h0, div_sel};
			end
			default:
			begin
				next_rdata = 32'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i &&
				req.addr != rsm_pkg::SEC_OFF &&
				req.addr != rsm_pkg::MIN_OFF &&
				req.addr != rsm_pkg::CTRL_OFF &&
				req.addr != rsm_pkg::DIV_OFF;
			if (psel_i && !penable_i && !req.write)
			begin
				prdata_o <= next_rdata;
			end
		end
	end

	// ==========================================================
	// assertions
	a_sec_range: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		sec_val.units <= 4'h9 || $past(sec_load))
		else $error("seconds units out of range");
	a_sec_tens: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		sec_val.tens <= 3'h5 || $past(sec_load))
		else $error("seconds tens out of range");
	a_min_step: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		!sec_wrap && !min_load |=> $stable(min_val))
		else $error("minutes moved without carry");
	a_sec_wraps: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		sec_step && !sec_load && sec_val == 7'h59 |=> sec_val == 7'h00)
		else $error("seconds did not wrap");
	a_min_wraps: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		sec_wrap && !min_load && min_val == 7'h59 |=> min_val == 7'h00)
		else $error("minutes did not wrap");
	a_min_units: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		sec_wrap && !min_load && min_val == 7'h09 |=> min_val == 7'h10)
		else $error("minutes units carry wrong");
	a_busy_len: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(busy) |-> busy [*2] ##1 !busy)
		else $error("busy length wrong");
	a_hour_carry: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		min_wrap |=> hour_carry_o)
		else $error("hour carry missing");
	a_free_ro: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		ctrl[rsm_pkg::CTRL_FREE_BIT] |=> $stable(sec_val))
		else $error("seconds moved in free mode");
	a_stop_hold: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		!ctrl[rsm_pkg::CTRL_RUN_BIT] ##1 !ctrl[rsm_pkg::CTRL_RUN_BIT]
		|-> !tick)
		else $error("tick while stopped");
	a_div_toggle: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		!tick |=> $stable(divided_clock_out_pin_o))
		else $error("divided clock moved without tick");

	c_min_carry: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		sec_wrap);
	c_hour: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		hour_carry_o);
	c_busy_read: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		rd_acc && busy);
	c_free: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl[rsm_pkg::CTRL_FREE_BIT] && tick);

endmodule

// ===== dv/tb_rsm_top.sv
// Purpose: self-checking bench for the seconds/minutes counter
// Assumes: apb zero-wait slave, TICK_DIV shortened to 8
// Notes: reads taken while busy are skipped, as software must
`timescale 1ns/1ns
module tb_rsm_top;
	// ==========================================================
	// signals
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic divided_clock_out_pin_o;
	logic hour_carry_o;
	int miscompares = 0;
	int checks_done = 0;
	int hc = 0;
	int tg = 0;
	int ticks;
	logic last_pin = 1'b0;
	logic saw_busy;
	logic [6:0] cur;
	logic [31:0] rd;
	logic er;

	rsm_top #(.TICK_DIV(8)) dut (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.divided_clock_out_pin_o(divided_clock_out_pin_o),
		.hour_carry_o(hour_carry_o)
	);

	// ==========================================================
	// clock, monitors, watchdog
	initial
	begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i)
	begin
		if (hour_carry_o === 1'b1) hc++;
		if (divided_clock_out_pin_o !== last_pin) tg++;
		last_pin = divided_clock_out_pin_o;
	end

	initial
	begin
		#80000;
		miscompares++;
		give_verdict();
	end

	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		paddr_i <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge sys_clk_i);
		end
		while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	function automatic logic [6:0] bcd_inc(input logic [6:0] v);
		if (v[3:0] == 4'h9)
			return (v[6:4] == 3'h5) ? 7'h00 : {v[6:4] + 3'h1, 4'h0};
		return {v[6:4], v[3:0] + 4'h1};
	endfunction

	// polls seconds, accepting only values read with busy clear
	task automatic poll(input int n);
		int seen;
		int guard;
		seen = 0;
		guard = 0;
		saw_busy = 1'b0;
		while (seen < n && guard < 2000)
		begin
			apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
			guard++;
			if (rd[7] === 1'b1)
				saw_busy = 1'b1;
			else if (rd[6:0] !== cur)
			begin
				chk("sec step", {25'h0, bcd_inc(cur)}, rd);
				cur = rd[6:0];
				seen++;
			end
		end
		chk("poll count", n, seen);
		ticks = seen;
	endtask

	// stops counting and folds in a tick that raced the stop
	task automatic stop_run();
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h0);
		repeat (4) @(posedge sys_clk_i);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		if (rd[6:0] !== cur)
		begin
			chk("late tick", {25'h0, bcd_inc(cur)}, rd);
			cur = rd[6:0];
			ticks++;
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		// reset values and unmapped place
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		chk("sec reset", 32'h0, rd);
		chk("ok err", 32'h0, {31'h0, er});
		apb(rsm_pkg::MIN_OFF, 1'b0, 32'h0);
		chk("min reset", 32'h0, rd);
		apb(rsm_pkg::CTRL_OFF, 1'b0, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(8'h10, 1'b1, 32'hff);
		chk("bad wr err", 32'h1, {31'h0, er});
		apb(8'h10, 1'b0, 32'h0);
		chk("bad rd err", 32'h1, {31'h0, er});
		chk("bad rd data", 32'h0, rd);
		// loads, with the busy bit written high
		apb(rsm_pkg::DIV_OFF, 1'b1, 32'h01);
		apb(rsm_pkg::DIV_OFF, 1'b0, 32'h0);
		chk("div rd", 32'h01, rd);
		apb(rsm_pkg::SEC_OFF, 1'b1, 32'hd7);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		chk("sec load", 32'h57, rd);
		apb(rsm_pkg::MIN_OFF, 1'b1, 32'hd9);
		apb(rsm_pkg::MIN_OFF, 1'b0, 32'h0);
		chk("min load", 32'h59, rd);
		cur = 7'h57;
		hc = 0;
		tg = 0;
		// 57 to 12 crosses both digit wraps and the minute wrap
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h1);
		poll(15);
		chk("busy seen", 32'h1, {31'h0, saw_busy});
		stop_run();
		apb(rsm_pkg::MIN_OFF, 1'b0, 32'h0);
		chk("min wrap", 32'h00, rd);
		chk("hour carry", 32'h1, hc);
		chk("pin toggles", ticks / 2, tg);
		repeat (40) @(posedge sys_clk_i);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		chk("stopped", {25'h0, cur}, rd);
		// minutes units wrap 09 to 10
		apb(rsm_pkg::SEC_OFF, 1'b1, 32'h59);
		apb(rsm_pkg::MIN_OFF, 1'b1, 32'h89);
		cur = 7'h59;
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h1);
		poll(1);
		stop_run();
		apb(rsm_pkg::MIN_OFF, 1'b0, 32'h0);
		chk("min tens", 32'h10, rd);
		// free-running counter
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h3);
		for (int i = 1; i <= 3; i++)
		begin
			do apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
			while (rd === i - 1);
			chk("free count", i, rd);
		end
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h2);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		ticks = rd;
		apb(rsm_pkg::SEC_OFF, 1'b1, 32'h33);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		chk("free no write", ticks, rd);
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h0);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		chk("bcd kept", {25'h0, cur}, rd);
		apb(rsm_pkg::CTRL_OFF, 1'b1, 32'h2);
		apb(rsm_pkg::SEC_OFF, 1'b0, 32'h0);
		chk("free cleared", 32'h0, rd);
		give_verdict();
	end
endmodule
